// ==== src/pci_burst_master.sv ====
// pci master end of a 32-bit burst write fed by a local master
// assumes pci inputs are synchronous to mclk_i (the pci clock)
// Overview of operation
// R1: local master holds ready while words remain
// R2: framen held low until final data phase
// R3: data phase done when irdyn and trdyn low
// R4: count drops one after each completed phase
// R5: next buffered word goes out after acceptance
// R6: irdyn kept low while local ready held
// R7: taken strobe after local ready seen asserted
// R8: local master drops ready after last word
// R9: last phase raises framen, drops taken strobe
// R10: turnaround releases frame, ad, cben; count zero
// R11: turnaround reports termination, normal end cause
// R12: target drops devseln and trdyn at turnaround
// R13: irdyn and par released one cycle later
// R14: request presents address, command, burst length
// R15: reqn on request; grant when bus idle
// R16: request plus grant latches address, command, length
// R17: address phase drives frame, loads burst count
// R18: distinct codes for phases and normal end
// R19: count reaching final word selects last phase
`timescale 1ns/10ps
module pci_burst_master #(
    parameter int BEATS_W = pci_tail_pkg::BEATS_W,
    parameter int DEPTH   = pci_tail_pkg::FIFO_DEPTH
) (
    input  wire logic                          mclk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          ce_i,
    pci_local_if.core                          lif,
    input  wire logic                          gnt_n_i,
    input  wire logic                          trdy_n_i,
    input  wire logic                          frame_n_i,
    input  wire logic                          irdy_n_i,
    output logic                               req_n_o,
    output logic [pci_tail_pkg::AD_W-1:0]      ad_o,
    output logic [pci_tail_pkg::BE_W-1:0]      cbe_o,
    output logic                               adcbe_oe_n_o,
    output logic                               frame_n_o,
    output logic                               frame_oe_n_o,
    output logic                               irdy_n_o,
    output logic                               irdy_oe_n_o,
    output logic                               par_o,
    output logic                               par_oe_n_o
);
    localparam int AD_W = pci_tail_pkg::AD_W;
    localparam int BE_W = pci_tail_pkg::BE_W;
    localparam int WW   = pci_tail_pkg::WORD_W;

    typedef enum logic [2:0] {
        S_IDLE, S_REQ, S_GRANT, S_LOAD, S_ADDR, S_DATA, S_TURN
    } state_e;

    state_e             state_r, state_nxt;
    logic               req_n_r, req_n_nxt, lgnt_n_r, lgnt_n_nxt;
    logic [3:0]         phase_r, phase_nxt, cause_r, cause_nxt;
    logic [AD_W-1:0]    addr_r, addr_nxt, ad_r, ad_nxt;
    logic [BE_W-1:0]    cmd_r, cmd_nxt, cbe_r, cbe_nxt;
    logic [BEATS_W-1:0] beats_r, beats_nxt, cnt_r, cnt_nxt;
    logic               ad_oe_n_r, ad_oe_n_nxt;
    logic               frame_n_r, frame_n_nxt, frame_oe_n_r, frame_oe_n_nxt;
    logic               irdy_n_r, irdy_n_nxt, irdy_oe_n_r, irdy_oe_n_nxt;
    logic               par_r, par_nxt, par_oe_n_r, par_oe_n_nxt;
    logic [BEATS_W-1:0] fetch_r, fetch_nxt;
    logic               take_n_r, take_n_nxt;
    logic               done_ph, pop, fifo_in_rdy, fifo_ov;
    logic [WW-1:0]      fifo_word;
    logic [BEATS_W-1:0] left;

    // word buffer between local side and pci side
    word_fifo #(.W(WW), .D(DEPTH)) u_fifo (
        .mclk_i      (mclk_i),
        .sys_rst_i   (sys_rst_i),
        .ce_i        (ce_i),
        .in_data_i   ({lif.local_cmd_byteen_input, lif.local_addr_data}),
        .in_valid_i  (~take_n_r),
        .in_ready_o  (fifo_in_rdy),
        .out_data_o  (fifo_word),
        .out_valid_o (fifo_ov),
        .out_ready_i (pop)
    );

    // local fetch: strobe a cycle after ready seen, never twice in a row
    always_comb begin
        fetch_nxt  = fetch_r;
        take_n_nxt = 1'b1;
        if (state_r == S_GRANT && !lif.narrow_request_n) begin
            fetch_nxt = lif.requested_beats;
        end else if ((state_r == S_LOAD || state_r == S_ADDR ||
                      state_r == S_DATA) && !lif.local_master_ready_n &&
                     take_n_r && fetch_r != '0 && fifo_in_rdy) begin
            take_n_nxt = 1'b0; // R7
            fetch_nxt  = fetch_r - 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fetch_r  <= '0;
            take_n_r <= 1'b1;
        end else if (ce_i) begin
            fetch_r  <= fetch_nxt;
            take_n_r <= take_n_nxt;
        end
    end

    // pci side sequencing
    always_comb begin
        state_nxt      = state_r;
        req_n_nxt      = req_n_r;
        lgnt_n_nxt     = lgnt_n_r;
        phase_nxt      = phase_r;
        cause_nxt      = cause_r;
        addr_nxt       = addr_r;
        cmd_nxt        = cmd_r;
        beats_nxt      = beats_r;
        cnt_nxt        = cnt_r;
        ad_nxt         = ad_r;
        cbe_nxt        = cbe_r;
        ad_oe_n_nxt    = ad_oe_n_r;
        frame_n_nxt    = frame_n_r;
        frame_oe_n_nxt = frame_oe_n_r;
        irdy_n_nxt     = irdy_n_r;
        irdy_oe_n_nxt  = irdy_oe_n_r;
        par_nxt        = ^{ad_r, cbe_r};
        par_oe_n_nxt   = ad_oe_n_r; // R13
        pop            = 1'b0;
        left           = cnt_r;
        done_ph        = !irdy_oe_n_r && !irdy_n_r && !trdy_n_i; // R3
        unique case (state_r)
            S_IDLE: begin
                phase_nxt = pci_tail_pkg::PH_IDLE;
                if (!lif.narrow_request_n) begin
                    req_n_nxt = 1'b0; // R15
                    state_nxt = S_REQ;
                end
            end
            S_REQ: begin
                if (!gnt_n_i && frame_n_i && irdy_n_i) begin
                    lgnt_n_nxt = 1'b0; // R15
                    state_nxt  = S_GRANT;
                end
            end
            S_GRANT: begin
                if (!lif.narrow_request_n) begin
                    phase_nxt = pci_tail_pkg::PH_ADDR_LOAD; // R16
                    addr_nxt  = lif.local_addr_data;
                    cmd_nxt   = lif.local_cmd_byteen_input;
                    beats_nxt = lif.requested_beats;
                    cause_nxt = pci_tail_pkg::END_NONE;
                    state_nxt = S_LOAD;
                end else begin
                    req_n_nxt  = 1'b1;
                    lgnt_n_nxt = 1'b1;
                    state_nxt  = S_IDLE;
                end
            end
            S_LOAD: begin
                lgnt_n_nxt = 1'b1;
                if (!gnt_n_i) begin
                    frame_n_nxt    = 1'b0; // R17
                    frame_oe_n_nxt = 1'b0;
                    ad_nxt         = addr_r;
                    cbe_nxt        = cmd_r;
                    ad_oe_n_nxt    = 1'b0;
                    irdy_n_nxt     = 1'b1;
                    irdy_oe_n_nxt  = 1'b0;
                    phase_nxt      = pci_tail_pkg::PH_BUS_TXN;
                    cnt_nxt        = beats_r; // R17
                    req_n_nxt      = 1'b1;
                    state_nxt      = S_ADDR;
                end else begin
                    phase_nxt = pci_tail_pkg::PH_IDLE;
                    state_nxt = S_REQ;
                end
            end
            S_ADDR, S_DATA: begin
                state_nxt = S_DATA;
                if (state_r == S_DATA && done_ph) begin
                    cnt_nxt = cnt_r - 1'b1; // R4
                    left    = cnt_r - 1'b1;
                end
                if (state_r == S_DATA && done_ph && cnt_r == 1) begin
                    frame_oe_n_nxt = 1'b1; // R10
                    ad_oe_n_nxt    = 1'b1; // R10
                    irdy_n_nxt     = 1'b1; // R10
                    phase_nxt      = pci_tail_pkg::PH_BUS_TERM; // R11
                    cause_nxt      = pci_tail_pkg::END_NORMAL; // R11
                    state_nxt      = S_TURN;
                end else if (state_r == S_ADDR || done_ph || irdy_n_r) begin
                    if (fifo_ov) begin
                        pop         = 1'b1; // R5
                        ad_nxt      = fifo_word[AD_W-1:0]; // R5
                        cbe_nxt     = fifo_word[WW-1:AD_W];
                        irdy_n_nxt  = 1'b0; // R6
                        frame_n_nxt = (left == 1); // R2 R9 R19
                    end else begin
                        irdy_n_nxt  = 1'b1;
                    end
                end
            end
            S_TURN: begin
                irdy_oe_n_nxt = 1'b1; // R13
                frame_n_nxt   = 1'b1;
                phase_nxt     = pci_tail_pkg::PH_IDLE;
                state_nxt     = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r      <= S_IDLE;
            req_n_r      <= 1'b1;
            lgnt_n_r     <= 1'b1;
            phase_r      <= pci_tail_pkg::PH_IDLE;
            cause_r      <= pci_tail_pkg::END_NONE;
            addr_r       <= '0;
            cmd_r        <= '0;
            beats_r      <= '0;
            cnt_r        <= '0;
            ad_r         <= '0;
            cbe_r        <= '0;
            ad_oe_n_r    <= 1'b1;
            frame_n_r    <= 1'b1;
            frame_oe_n_r <= 1'b1;
            irdy_n_r     <= 1'b1;
            irdy_oe_n_r  <= 1'b1;
            par_r        <= 1'b0;
            par_oe_n_r   <= 1'b1;
        end else if (ce_i) begin
            state_r      <= state_nxt;
            req_n_r      <= req_n_nxt;
            lgnt_n_r     <= lgnt_n_nxt;
            phase_r      <= phase_nxt;
            cause_r      <= cause_nxt;
            addr_r       <= addr_nxt;
            cmd_r        <= cmd_nxt;
            beats_r      <= beats_nxt;
            cnt_r        <= cnt_nxt;
            ad_r         <= ad_nxt;
            cbe_r        <= cbe_nxt;
            ad_oe_n_r    <= ad_oe_n_nxt;
            frame_n_r    <= frame_n_nxt;
            frame_oe_n_r <= frame_oe_n_nxt;
            irdy_n_r     <= irdy_n_nxt;
            irdy_oe_n_r  <= irdy_oe_n_nxt;
            par_r        <= par_nxt;
            par_oe_n_r   <= par_oe_n_nxt;
        end
    end

    // all outputs straight from registers
    assign req_n_o                   = req_n_r;
    assign ad_o                      = ad_r;
    assign cbe_o                     = cbe_r;
    assign adcbe_oe_n_o              = ad_oe_n_r;
    assign frame_n_o                 = frame_n_r;
    assign frame_oe_n_o              = frame_oe_n_r;
    assign irdy_n_o                  = irdy_n_r;
    assign irdy_oe_n_o               = irdy_oe_n_r;
    assign par_o                     = par_r;
    assign par_oe_n_o                = par_oe_n_r;
    assign lif.local_grant_n         = lgnt_n_r;
    assign lif.local_word_taken_n    = take_n_r;
    assign lif.remaining_beats_count = cnt_r;
    assign lif.local_phase_state     = phase_r;
    assign lif.end_cause_code        = cause_r;
endmodule

// ==== src/pci_tail_pkg.sv ====
// shared constants for the 32-bit burst write master and its local master
// assumes both ends run on the one pci clock
package pci_tail_pkg;
    // bus and word widths, beat count width and fifo depth
    localparam int AD_W       = 32;
    localparam int BE_W       = 4;
    localparam int BEATS_W    = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int WORD_W     = AD_W + BE_W;

    // local phase state codes
    localparam logic [3:0] PH_IDLE      = 4'h0; // R18
    localparam logic [3:0] PH_ADDR_LOAD = 4'h1;
    localparam logic [3:0] PH_BUS_TXN   = 4'h2;
    localparam logic [3:0] PH_BUS_TERM  = 4'h3;

    // end cause codes
    localparam logic [3:0] END_NONE   = 4'h0;
    localparam logic [3:0] END_NORMAL = 4'h1; // R18
endpackage

// ==== src/pci_local_if.sv ====
// local master side signals between the burst core and its local master
// assumes both parties sample on the same pci clock
`timescale 1ns/10ps
interface pci_local_if #(parameter int BEATS_W = pci_tail_pkg::BEATS_W);
    logic                          narrow_request_n;
    logic                          local_grant_n;
    logic                          local_master_ready_n;
    logic                          local_word_taken_n;
    logic [pci_tail_pkg::AD_W-1:0] local_addr_data;
    logic [pci_tail_pkg::BE_W-1:0] local_cmd_byteen_input;
    logic [BEATS_W-1:0]            requested_beats;
    logic [BEATS_W-1:0]            remaining_beats_count;
    logic [3:0]                    local_phase_state;
    logic [3:0]                    end_cause_code;

    modport core (
        input  narrow_request_n, local_master_ready_n, local_addr_data,
               local_cmd_byteen_input, requested_beats,
        output local_grant_n, local_word_taken_n, remaining_beats_count,
               local_phase_state, end_cause_code
    );
    modport lm (
        output narrow_request_n, local_master_ready_n, local_addr_data,
               local_cmd_byteen_input, requested_beats,
        input  local_grant_n, local_word_taken_n, remaining_beats_count,
               local_phase_state, end_cause_code
    );
endinterface

// ==== src/word_fifo.sv ====
// synchronous fifo with valid/ready on both sides
// assumes one clock; ce_i low freezes it
`timescale 1ns/10ps
module word_fifo #(
    parameter int W = 36,
    parameter int D = 16
) (
    input  wire logic         mclk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_r [D];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    // handshakes and pointer steps
    always_comb begin
        push    = in_valid_i & in_ready_o;
        pop     = out_valid_o & out_ready_i;
        wr_nxt  = push ? ((wr_r == AW'(D - 1)) ? '0 : wr_r + 1'b1) : wr_r;
        rd_nxt  = pop ? ((rd_r == AW'(D - 1)) ? '0 : rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    assign in_ready_o  = (cnt_r != (AW+1)'(D)); // honest full
    assign out_valid_o = (cnt_r != '0);         // honest empty
    assign out_data_o  = mem_r[rd_r];

    // pointers and count
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else if (ce_i) begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage, no reset needed
    always_ff @(posedge mclk_i) begin
        if (ce_i && push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end
endmodule

// ==== src/local_burst_source.sv ====
// local master end: requests one burst write and feeds its words
// assumes the core and this end share mclk_i
`timescale 1ns/10ps
module local_burst_source #(
    parameter int BEATS_W = pci_tail_pkg::BEATS_W
) (
    input  wire logic                          mclk_i,
    input  wire logic                          sys_rst_i,
    input  wire logic                          ce_i,
    pci_local_if.lm                            lif,
    input  wire logic                          start_i,
    input  wire logic [pci_tail_pkg::AD_W-1:0] start_addr_i,
    input  wire logic [pci_tail_pkg::BE_W-1:0] cmd_i,
    input  wire logic [BEATS_W-1:0]            beats_i,
    input  wire logic [pci_tail_pkg::AD_W-1:0] word_i,
    input  wire logic [pci_tail_pkg::BE_W-1:0] byteen_i,
    input  wire logic                          word_valid_i,
    output logic                               word_ready_o,
    output logic                               busy_o,
    output logic [3:0]                         end_cause_o
);
    localparam int AD_W = pci_tail_pkg::AD_W;
    localparam int BE_W = pci_tail_pkg::BE_W;

    logic               busy_r, busy_nxt, reqn_r, reqn_nxt;
    logic               hold_r, hold_nxt, rdy_r, rdy_nxt, rdyn_r, rdyn_nxt;
    logic [BEATS_W-1:0] left_r, left_nxt, beats_r, beats_nxt;
    logic [AD_W-1:0]    ad_r, ad_nxt, word_r, word_nxt;
    logic [BE_W-1:0]    be_r, be_nxt, bw_r, bw_nxt;
    logic [3:0]         cause_r, cause_nxt;

    // request, word holding and ready
    always_comb begin
        busy_nxt  = busy_r;
        reqn_nxt  = reqn_r;
        hold_nxt  = hold_r;
        left_nxt  = left_r;
        beats_nxt = beats_r;
        word_nxt  = word_r;
        bw_nxt    = bw_r;
        cause_nxt = cause_r;
        ad_nxt    = ad_r;
        be_nxt    = be_r;
        if (!busy_r && start_i) begin
            busy_nxt  = 1'b1;
            reqn_nxt  = 1'b0; // R14
            left_nxt  = beats_i;
            beats_nxt = beats_i;
            ad_nxt    = start_addr_i; // R14
            be_nxt    = cmd_i;
        end
        if (!reqn_r &&
            lif.local_phase_state == pci_tail_pkg::PH_ADDR_LOAD) begin
            reqn_nxt = 1'b1;
        end
        if (busy_r && !lif.local_word_taken_n && left_r != '0) begin
            hold_nxt = 1'b0;
            left_nxt = left_r - 1'b1;
        end
        if (rdy_r && word_valid_i) begin
            hold_nxt = 1'b1;
            word_nxt = word_i;
            bw_nxt   = byteen_i;
        end
        if (busy_r && reqn_nxt && !hold_r && hold_nxt) begin
            ad_nxt = word_i; // data as soon as address latched
            be_nxt = byteen_i;
        end else if (busy_r && reqn_nxt && hold_r) begin
            ad_nxt = word_r;
            be_nxt = bw_r;
        end
        if (busy_r && lif.local_phase_state == pci_tail_pkg::PH_BUS_TERM) begin
            busy_nxt  = 1'b0;
            cause_nxt = lif.end_cause_code;
            hold_nxt  = 1'b0;
        end
        rdy_nxt  = busy_nxt && !hold_nxt && left_nxt != '0;
        rdyn_nxt = !(busy_nxt && hold_nxt && left_nxt != '0); // R1 R8
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            busy_r  <= 1'b0;
            reqn_r  <= 1'b1;
            hold_r  <= 1'b0;
            rdy_r   <= 1'b0;
            rdyn_r  <= 1'b1;
            left_r  <= '0;
            beats_r <= '0;
            ad_r    <= '0;
            be_r    <= '0;
            word_r  <= '0;
            bw_r    <= '0;
            cause_r <= pci_tail_pkg::END_NONE;
        end else if (ce_i) begin
            busy_r  <= busy_nxt;
            reqn_r  <= reqn_nxt;
            hold_r  <= hold_nxt;
            rdy_r   <= rdy_nxt;
            rdyn_r  <= rdyn_nxt;
            left_r  <= left_nxt;
            beats_r <= beats_nxt;
            ad_r    <= ad_nxt;
            be_r    <= be_nxt;
            word_r  <= word_nxt;
            bw_r    <= bw_nxt;
            cause_r <= cause_nxt;
        end
    end

    assign word_ready_o               = rdy_r;
    assign busy_o                     = busy_r;
    assign end_cause_o                = cause_r;
    assign lif.narrow_request_n       = reqn_r;
    assign lif.local_master_ready_n   = rdyn_r;
    assign lif.local_addr_data        = ad_r;
    assign lif.local_cmd_byteen_input = be_r;
    assign lif.requested_beats        = beats_r;
endmodule

// ==== tb/pci_master_burst_write_tail_props.sv ====
// concurrent checks on the local link and pci pins of the burst core
// assumes one clock; the bench instantiates it beside the link interface
`timescale 1ns/10ps
module pci_tail_props #(
    parameter int BEATS_W = 8
) (
    input wire logic               mclk_i,
    input wire logic               sys_rst_i,
    input wire logic               narrow_request_n,
    input wire logic               local_grant_n,
    input wire logic               local_master_ready_n,
    input wire logic               local_word_taken_n,
    input wire logic [BEATS_W-1:0] requested_beats,
    input wire logic [BEATS_W-1:0] remaining_beats_count,
    input wire logic [3:0]         local_phase_state,
    input wire logic [3:0]         end_cause_code,
    input wire logic               req_n_o,
    input wire logic               gnt_n_i,
    input wire logic               trdy_n_i,
    input wire logic               irdy_n_o,
    input wire logic               irdy_oe_n_o,
    input wire logic               frame_n_o,
    input wire logic               frame_oe_n_o,
    input wire logic               adcbe_oe_n_o,
    input wire logic               par_oe_n_o
);
    localparam logic [3:0] IDLE = pci_tail_pkg::PH_IDLE;
    localparam logic [3:0] LOAD = pci_tail_pkg::PH_ADDR_LOAD;
    localparam logic [3:0] TXN  = pci_tail_pkg::PH_BUS_TXN;
    localparam logic [3:0] TERM = pci_tail_pkg::PH_BUS_TERM;
    localparam logic [3:0] NORM = pci_tail_pkg::END_NORMAL;

    default clocking dflt @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    // last data phase completing, then turnaround, then idle bus
    sequence last_done;
        local_phase_state == TXN && frame_n_o && !frame_oe_n_o &&
            !irdy_n_o && !trdy_n_i;
    endsequence
    sequence turnaround;
        local_phase_state == TERM && frame_oe_n_o && adcbe_oe_n_o &&
            irdy_n_o && remaining_beats_count == 0 && end_cause_code == NORM;
    endsequence
    sequence released;
        irdy_oe_n_o && par_oe_n_o && local_phase_state == IDLE;
    endsequence

    req_issue_a: assert property (
        local_phase_state == IDLE && !narrow_request_n |=> !req_n_o)
        else $error("bus request not raised");
    load_entry_a: assert property (
        local_phase_state == IDLE && !narrow_request_n && !local_grant_n
        |=> local_phase_state == LOAD)
        else $error("address loading not entered");
    addr_phase_a: assert property (
        local_phase_state == LOAD && !gnt_n_i |=> local_phase_state == TXN
        && !frame_n_o && !frame_oe_n_o
        && remaining_beats_count == $past(requested_beats))
        else $error("address phase wrong");
    count_step_a: assert property (
        local_phase_state == TXN && !irdy_n_o && !trdy_n_i
        |=> remaining_beats_count == $past(remaining_beats_count) - 1'b1)
        else $error("count not decremented");
    count_hold_a: assert property (
        local_phase_state == TXN && (irdy_n_o || trdy_n_i)
        |=> $stable(remaining_beats_count))
        else $error("count moved without completion");
    frame_hold_a: assert property (
        local_phase_state == TXN && remaining_beats_count > 1 |-> !frame_n_o)
        else $error("frame released early");
    last_phase_a: assert property (
        local_phase_state == TXN && frame_n_o && !frame_oe_n_o
        |-> remaining_beats_count == 1 && local_word_taken_n)
        else $error("last phase wrong");
    end_report_a: assert property (
        last_done |=> turnaround)
        else $error("turnaround wrong");
    bus_idle_a: assert property (
        last_done ##1 turnaround |=> released)
        else $error("irdy or par not released");
    take_pulse_a: assert property (
        !local_word_taken_n |=> local_word_taken_n)
        else $error("taken strobe too long");
    take_cause_a: assert property (
        $fell(local_word_taken_n) |-> !$past(local_master_ready_n))
        else $error("taken strobe without ready");
endmodule

// ==== tb/pci_master_burst_write_tail_tb_top.sv ====
// bench: burst core and local master joined by the link, bench is target
// assumes the 20 MHz pci clock and pulled-up frame and irdy lines
`timescale 1ns/10ps
module pci_master_burst_write_tail_tb_top;
    logic        mclk_i, sys_rst_i, start_i, word_valid_i, gnt_n_i, trdy_n_i;
    logic [31:0] start_addr_i, word_i, ad_o, ad_q;
    logic [3:0]  cmd_i, byteen_i, cbe_o, cb_q, end_cause_o;
    logic [7:0]  beats_i;
    logic        word_ready_o, busy_o, req_n_o, adcbe_oe_n_o, frame_n_o;
    logic        frame_oe_n_o, irdy_n_o, irdy_oe_n_o, par_o, par_oe_n_o;
    wire         frame_n_i, irdy_n_i;
    logic [35:0] got_q[$], got_a;
    logic [1:0]  cyc = 2'h0;
    bit          in_txn, done, drv_q, stall_en;
    int          fails = 0;
    int          cmp_count = 0;

    pci_local_if lif ();
    pci_burst_master i_pci_burst_master (.mclk_i, .sys_rst_i, .ce_i(1'b1),
        .lif, .gnt_n_i, .trdy_n_i, .frame_n_i, .irdy_n_i, .req_n_o, .ad_o,
        .cbe_o, .adcbe_oe_n_o, .frame_n_o, .frame_oe_n_o, .irdy_n_o,
        .irdy_oe_n_o, .par_o, .par_oe_n_o);
    local_burst_source i_local_burst_source (.mclk_i, .sys_rst_i,
        .ce_i(1'b1), .lif, .start_i, .start_addr_i, .cmd_i, .beats_i,
        .word_i, .byteen_i, .word_valid_i, .word_ready_o, .busy_o,
        .end_cause_o);
    pci_tail_props props (.mclk_i, .sys_rst_i,
        .narrow_request_n(lif.narrow_request_n),
        .local_grant_n(lif.local_grant_n),
        .local_master_ready_n(lif.local_master_ready_n),
        .local_word_taken_n(lif.local_word_taken_n),
        .requested_beats(lif.requested_beats),
        .remaining_beats_count(lif.remaining_beats_count),
        .local_phase_state(lif.local_phase_state),
        .end_cause_code(lif.end_cause_code), .req_n_o, .gnt_n_i, .trdy_n_i,
        .irdy_n_o, .irdy_oe_n_o, .frame_n_o, .frame_oe_n_o, .adcbe_oe_n_o,
        .par_oe_n_o);

    // released bus lines float high through the pull-ups
    assign frame_n_i = frame_oe_n_o ? 1'b1 : frame_n_o;
    assign irdy_n_i = irdy_oe_n_o ? 1'b1 : irdy_n_o;

    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    task automatic chk(input string nm, input logic [35:0] e,
                       input logic [35:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic results;
        if (fails == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // arbiter and target: grant follows request, trdy held until completion
    always @(posedge mclk_i) begin
        done = !irdy_n_i && !trdy_n_i;
        if (!par_oe_n_o && drv_q)
            chk("parity", {35'h0, ^{ad_q, cb_q}}, {35'h0, par_o});
        drv_q = !adcbe_oe_n_o;
        ad_q = ad_o;
        cb_q = cbe_o;
        if (done) got_q.push_back({cbe_o, ad_o});
        if (done && frame_n_i) begin
            in_txn = 1'b0;
        end else if (!frame_n_i && !in_txn) begin
            in_txn = 1'b1;
            got_a = {cbe_o, ad_o};
        end
        cyc++;
        #2;
        gnt_n_i = req_n_o;
        if (!in_txn) trdy_n_i = 1'b1;
        else if (trdy_n_i || done) trdy_n_i = stall_en && cyc != 2'h3;
    end

    // one burst: request, feed words, then compare what the target took
    task automatic burst(input int n, input bit ts, input bit fg);
        logic [31:0] addr;
        bit          ok;
        addr = 32'h0000_4000 + 32'(n * 16);
        stall_en = ts;
        start_addr_i = addr;
        cmd_i = 4'h7;
        beats_i = 8'(n);
        start_i = 1'b1;
        @(posedge mclk_i);
        #2;
        start_i = 1'b0;
        for (int k = 0; k < n; k++) begin
            word_i = {16'hc0de, 8'(n), 8'(k)};
            byteen_i = 4'(k) ^ 4'ha;
            word_valid_i = 1'b1;
            do begin
                ok = word_ready_o;
                @(posedge mclk_i);
                #2;
            end while (!ok);
            if (fg && k[0]) begin
                word_valid_i = 1'b0;
                repeat (3) @(posedge mclk_i);
                #2;
            end
        end
        word_valid_i = 1'b0;
        for (int k = 0; k < 300 && busy_o !== 1'b0; k++) @(posedge mclk_i);
        repeat (4) @(posedge mclk_i);
        #2;
        chk("busy", 36'h0, {35'h0, busy_o});
        chk("address", {cmd_i, addr}, got_a);
        chk("beats", 36'(n), 36'(got_q.size()));
        for (int k = 0; k < n; k++)
            chk("word", {4'(k)^4'ha, 16'hc0de, 8'(n), 8'(k)}, got_q[k]);
        chk("left", 36'h0, {28'h0, lif.remaining_beats_count});
        chk("cause", 36'(pci_tail_pkg::END_NORMAL), 36'(end_cause_o));
        got_q = {};
    endtask

    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        results;
    end

    initial begin
        sys_rst_i = 1'b1;
        start_i = 1'b0;
        word_valid_i = 1'b0;
        gnt_n_i = 1'b1;
        trdy_n_i = 1'b1;
        start_addr_i = 32'h0;
        word_i = 32'h0;
        cmd_i = 4'h0;
        byteen_i = 4'h0;
        beats_i = 8'h0;
        repeat (10) @(posedge mclk_i);
        #2;
        sys_rst_i = 1'b0;
        burst(3, 1'b0, 1'b0);
        burst(1, 1'b0, 1'b0);
        burst(20, 1'b1, 1'b0);
        burst(5, 1'b0, 1'b1);
        burst(2, 1'b1, 1'b1);
        results;
    end
endmodule
